// >>> design/pmr_result_regs.v
// Functional notes
// RULE_01 - sense reading stored 16-bit two's complement
// RULE_02 - sense count 2.5 uV, 7FFF is 81.92 mV
// RULE_03 - averaging on: registers show averaged results
// RULE_04 - bus register holds latest bus reading
// RULE_05 - bus register bit 15 reads zero
// RULE_06 - power count weighs 25 current counts
// RULE_07 - power is current times bus value
// RULE_08 - power unsigned sixteen bits, never negative
// RULE_09 - indices 01h 02h 03h, sense/power reset zero
// RULE_10 - current is sense times calibration
// RULE_11 - read-only, update only when sequence completes
`include "pmr_defs.vh"
module pmr_result_regs #(
	parameter W = 16
) (
	input wire clock,
	input wire rst,
	input wire conv_sense_valid,
	input wire [W-1:0] shunt_drop_reading,
	input wire conv_rail_valid,
	input wire [W-1:0] rail_level_reading,
	input wire [W-1:0] calib_value,
	input wire [2:0] avg_select,
	input wire reg_rd,
	input wire reg_wr,
	input wire [7:0] reg_index,
	input wire [W-1:0] reg_wdata,
	output reg [W-1:0] reg_rdata,
	output reg [W-1:0] sense_drop_result,
	output reg [W-1:0] rail_level_result,
	output reg [W-1:0] power_result,
	output reg [W-1:0] current_result,
	output reg update_pulse
);
	localparam SW = W + 11;
	// =====================================================
	// averaging depth from the mode code
	reg [10:0] avg_count;
	reg [3:0] avg_shift;
	always @* begin
		case (avg_select)
		3'd0: begin
			avg_count = 11'd1;
			avg_shift = 4'd0;
		end
		3'd1: begin
			avg_count = 11'd4;
			avg_shift = 4'd2;
		end
		3'd2: begin
			avg_count = 11'd16;
			avg_shift = 4'd4;
		end
		3'd3: begin
			avg_count = 11'd64;
			avg_shift = 4'd6;
		end
		3'd4: begin
			avg_count = 11'd128;
			avg_shift = 4'd7;
		end
		3'd5: begin
			avg_count = 11'd256;
			avg_shift = 4'd8;
		end
		3'd6: begin
			avg_count = 11'd512;
			avg_shift = 4'd9;
		end
		default: begin
			avg_count = 11'd1024;
			avg_shift = 4'd10;
		end
		endcase
	end
	// =====================================================
	// restart averaging when the depth changes, so no mixed group leaks out
	reg [2:0] avg_sel_reg;
	wire avg_restart;
	assign avg_restart = (avg_sel_reg != avg_select);
	always @(posedge clock or posedge rst) begin
		if (rst)
			avg_sel_reg <= 3'd0;
		else
			avg_sel_reg <= avg_select;
	end
	// =====================================================
	// two accumulators, one per channel
	wire [SW-1:0] sense_sum;
	wire [SW-1:0] rail_sum;
	wire sense_done;
	wire rail_done;
	pmr_accum #(.W(W), .SW(SW)) u_sense_acc (
		.clock(clock),
		.rst(rst),
		.clear(avg_restart),
		.sample_valid(conv_sense_valid),
		.sample(shunt_drop_reading),
		.count_target(avg_count),
		.sum_reg(sense_sum),
		.done_reg(sense_done)
	);
	// bus reading is masked to 15 bits so the sum stays positive
	wire [W-1:0] rail_sample;
	assign rail_sample = {1'b0, rail_level_reading[W-2:0]}; // RULE_05
	pmr_accum #(.W(W), .SW(SW)) u_rail_acc (
		.clock(clock),
		.rst(rst),
		.clear(avg_restart),
		.sample_valid(conv_rail_valid),
		.sample(rail_sample),
		.count_target(avg_count),
		.sum_reg(rail_sum),
		.done_reg(rail_done)
	);
	// =====================================================
	// right shift divides the sum by the power-of-two depth: arithmetic for sense, logical for bus
	wire signed [SW-1:0] sense_avg_full;
	wire [SW-1:0] rail_avg_full;
	assign sense_avg_full = $signed(sense_sum) >>> avg_shift; // RULE_03
	assign rail_avg_full = rail_sum >> avg_shift; // RULE_03
	// =====================================================
	// result registers; writes from the host never reach them
	reg sense_upd;
	reg rail_upd;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sense_drop_result <= `PMR_RST_SENSE; // RULE_09
			rail_level_result <= `PMR_RST_RAIL;
			sense_upd <= 1'b0;
			rail_upd <= 1'b0;
		end else begin
			sense_upd <= sense_done;
			rail_upd <= rail_done;
			if (sense_done)
				// code kept raw: 2.5 uV per count, sign in bit 15
				sense_drop_result <= sense_avg_full[W-1:0]; // RULE_01 RULE_02 RULE_11
			if (rail_done)
				rail_level_result <= {1'b0, rail_avg_full[W-2:0]}; // RULE_04 RULE_05
		end
	end
	// =====================================================
	// current = sense * calibration, sign handled by magnitude
	wire [W-1:0] sense_mag;
	wire [W-1:0] cal15;
	wire sense_neg;
	assign sense_neg = sense_drop_result[`PMR_SIGN_BIT];
	assign sense_mag = sense_neg ? (~sense_drop_result + 16'h0001) : sense_drop_result;
	assign cal15 = {1'b0, calib_value[W-2:0]};
	wire [2*W-1:0] cur_prod;
	wire cur_done;
	pmr_mul #(.W(W)) u_cur_mul (
		.clock(clock),
		.rst(rst),
		.start(sense_upd),
		.a(sense_mag),
		.b(cal15),
		.product_reg(cur_prod),
		.done_reg(cur_done)
	);
	// current magnitude truncated to 15 bits; scaling set by calibration
	wire [W-1:0] cur_mag;
	assign cur_mag = {1'b0, cur_prod[W-2:0]};
	reg cur_ready;
	reg rail_seen;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			current_result <= 16'h0000;
			cur_ready <= 1'b0;
		end else begin
			cur_ready <= cur_done;
			if (cur_done)
				current_result <= sense_neg ? (~cur_mag + 16'h0001) : cur_mag; // RULE_10
		end
	end
	// =====================================================
	// power = |current| * bus; one count weighs 25 current counts
	wire [W-1:0] cur_abs;
	assign cur_abs = current_result[W-1] ? (~current_result + 16'h0001) : current_result;
	// a fresh bus result waits only in the sense_upd cycle that starts a current update, not for the whole multiply
	wire pwr_start;
	assign pwr_start = cur_ready | (rail_seen & ~cur_ready & ~sense_upd);
	// set wins over clear: a bus update in a start cycle costs one extra product only
	always @(posedge clock or posedge rst) begin
		if (rst)
			rail_seen <= 1'b0;
		else if (rail_upd)
			rail_seen <= 1'b1;
		else if (pwr_start)
			rail_seen <= 1'b0;
	end
	wire [2*W-1:0] pwr_prod;
	wire pwr_done;
	pmr_mul #(.W(W)) u_pwr_mul (
		.clock(clock),
		.rst(rst),
		.start(pwr_start),
		.a(cur_abs),
		.b(rail_level_result),
		.product_reg(pwr_prod),
		.done_reg(pwr_done)
	);
	// divide by 25 to land on the coarser power step; saturate at full scale
	wire [2*W-1:0] pwr_scaled;
	assign pwr_scaled = pwr_prod / `PMR_POWER_RATIO; // RULE_06
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			power_result <= `PMR_RST_POWER; // RULE_09
			update_pulse <= 1'b0;
		end else begin
			update_pulse <= pwr_done;
			if (pwr_done)
				power_result <= (|pwr_scaled[2*W-1:W]) ? 16'hffff
					: pwr_scaled[W-1:0]; // RULE_07 RULE_08 RULE_11
		end
	end
	// =====================================================
	// read port: registered data, unmapped reads zero, writes ignored
	always @(posedge clock or posedge rst) begin
		if (rst)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			case (reg_index)
			`PMR_IDX_SENSE: reg_rdata <= sense_drop_result; // RULE_09
			`PMR_IDX_RAIL: reg_rdata <= rail_level_result; // RULE_09
			`PMR_IDX_POWER: reg_rdata <= power_result; // RULE_09
			`PMR_IDX_CURRENT: reg_rdata <= current_result;
			default: reg_rdata <= 16'h0000;
			endcase
		end
	end
	// reg_wr and reg_wdata are accepted and dropped: all results read-only
	wire unused_wr;
	assign unused_wr = reg_wr & (|reg_wdata); // RULE_11
endmodule

// >>> inc/pmr_defs.vh
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH
// =====================================================
// register indices
`define PMR_IDX_SENSE 8'h01
`define PMR_IDX_RAIL 8'h02
`define PMR_IDX_POWER 8'h03
`define PMR_IDX_CURRENT 8'h04
`define PMR_IDX_CALIB 8'h05
// =====================================================
// reset values
`define PMR_RST_SENSE 16'h0000
`define PMR_RST_RAIL 16'h0000
`define PMR_RST_POWER 16'h0000
// =====================================================
// field positions and scaling
`define PMR_SIGN_BIT 15
`define PMR_SENSE_LSB_NV 2500
`define PMR_SENSE_FS_CODE 16'h7fff
`define PMR_SENSE_FS_UV 81920
`define PMR_POWER_RATIO 25
`define PMR_MUL_CYCLES 5'd18
`endif

// >>> design/pmr_accum.v
`include "pmr_defs.vh"
// =====================================================
// signed running sum over a programmable sample count
module pmr_accum #(
	parameter W = 16,
	parameter SW = 27
) (
	input wire clock,
	input wire rst,
	input wire clear,
	input wire sample_valid,
	input wire [W-1:0] sample,
	input wire [10:0] count_target,
	output reg [SW-1:0] sum_reg,
	output reg done_reg
);
	reg [10:0] count_reg;
	// =====================================================
	// accumulate; done pulses on the last sample of a group
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sum_reg <= {SW{1'b0}};
			count_reg <= 11'h000;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (clear) begin
				sum_reg <= {SW{1'b0}};
				count_reg <= 11'h000;
			end else if (sample_valid) begin
				if (count_reg + 11'h001 >= count_target) begin
					done_reg <= 1'b1;
					count_reg <= 11'h000;
				end else begin
					count_reg <= count_reg + 11'h001;
				end
				sum_reg <= ((count_reg == 11'h000) ? {SW{1'b0}} : sum_reg)
					+ {{(SW-W){sample[W-1]}}, sample};
			end
		end
	end
endmodule

// >>> design/pmr_mul.v
`include "pmr_defs.vh"
// =====================================================
// sequential shift-add multiplier, unsigned operands
module pmr_mul #(
	parameter W = 16
) (
	input wire clock,
	input wire rst,
	input wire start,
	input wire [W-1:0] a,
	input wire [W-1:0] b,
	output reg [2*W-1:0] product_reg,
	output reg done_reg
);
	reg [2*W-1:0] acc_reg;
	reg [2*W-1:0] mcand_reg;
	reg [W-1:0] mplier_reg;
	reg [4:0] step_reg;
	reg busy_reg;
	// =====================================================
	// one bit per cycle; small area over speed, result far faster than a conversion
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_reg <= {2*W{1'b0}};
			mcand_reg <= {2*W{1'b0}};
			mplier_reg <= {W{1'b0}};
			step_reg <= 5'd0;
			busy_reg <= 1'b0;
			product_reg <= {2*W{1'b0}};
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (start) begin
				acc_reg <= {2*W{1'b0}};
				mcand_reg <= {{W{1'b0}}, a};
				mplier_reg <= b;
				step_reg <= 5'd0;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (mplier_reg[0])
					acc_reg <= acc_reg + mcand_reg;
				mcand_reg <= {mcand_reg[2*W-2:0], 1'b0};
				mplier_reg <= {1'b0, mplier_reg[W-1:1]};
				step_reg <= step_reg + 5'd1;
				if (step_reg == W[4:0]) begin
					busy_reg <= 1'b0;
					product_reg <= acc_reg;
					done_reg <= 1'b1;
				end
			end
		end
	end
endmodule

// >>> sim/pmr_result_regs_checker.sv
module pmr_chk #(
	parameter W = 16
) (
	input wire clock,
	input wire rst,
	input wire conv_sense_valid,
	input wire [W-1:0] shunt_drop_reading,
	input wire conv_rail_valid,
	input wire [W-1:0] rail_level_reading,
	input wire [W-1:0] calib_value,
	input wire [2:0] avg_select,
	input wire reg_rd,
	input wire reg_wr,
	input wire [7:0] reg_index,
	input wire [W-1:0] reg_wdata,
	input wire [W-1:0] reg_rdata,
	input wire [W-1:0] sense_drop_result,
	input wire [W-1:0] rail_level_result,
	input wire [W-1:0] power_result,
	input wire [W-1:0] current_result,
	input wire update_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ==========================================
	// read path and result fields
	AST_RAIL_MSB: assert property (rail_level_result[15] == 1'b0)
		else $error("rail result msb set");
	AST_RD_SENSE: assert property (reg_rd && reg_index == 8'h01
		|=> reg_rdata == $past(sense_drop_result))
		else $error("sense read mismatch");
	AST_RD_RAIL: assert property (reg_rd && reg_index == 8'h02
		|=> reg_rdata == $past(rail_level_result))
		else $error("rail read mismatch");
	AST_RD_POWER: assert property (reg_rd && reg_index == 8'h03
		|=> reg_rdata == $past(power_result))
		else $error("power read mismatch");
	AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	// single-sample latency only holds with averaging off
	AST_SENSE_LAT: assert property (conv_sense_valid && avg_select == 3'h0
		|-> ##2 sense_drop_result == $past(shunt_drop_reading, 2))
		else $error("sense result not stored");
	AST_RAIL_LAT: assert property (conv_rail_valid && avg_select == 3'h0
		|-> ##2 rail_level_result == {1'b0, $past(rail_level_reading[14:0], 2)})
		else $error("rail result not stored");
	AST_PWR_PULSE: assert property (!$stable(power_result) |-> update_pulse)
		else $error("power changed without update pulse");
	AST_PULSE_ONE: assert property (update_pulse |=> !update_pulse)
		else $error("update pulse longer than one cycle");
endmodule
bind pmr_result_regs pmr_chk #(.W(W)) i_chk (.clock, .rst, .conv_sense_valid, .shunt_drop_reading,
	.conv_rail_valid, .rail_level_reading, .calib_value, .avg_select, .reg_rd, .reg_wr, .reg_index,
	.reg_wdata, .reg_rdata, .sense_drop_result, .rail_level_result, .power_result, .current_result,
	.update_pulse);

// >>> sim/pmr_host.sv
// ==========================================
// host side: one-cycle read and write strobes
module pmr_host (
	input wire clock,
	input wire [15:0] reg_rdata,
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] reg_index,
	output logic [15:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus levels from time zero
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_index = 8'h00;
		reg_wdata = 16'h0000;
	end
	// released index shows its inverse so stale values never look valid
	task rd(input logic [7:0] idx, output logic [15:0] d);
		@(negedge clock);
		reg_rd = 1'b1;
		reg_index = idx;
		@(negedge clock);
		reg_rd = 1'b0;
		reg_index = ~idx;
		d = reg_rdata;
	endtask
	task wr(input logic [7:0] idx, input logic [15:0] v);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_index = idx;
		reg_wdata = v;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_index = ~idx;
		reg_wdata = ~v;
	endtask
endmodule

// >>> sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst, conv_sense_valid, conv_rail_valid, reg_rd, reg_wr, update_pulse;
	logic [15:0] shunt_drop_reading, rail_level_reading, calib_value, reg_wdata, reg_rdata, d;
	logic [15:0] sense_drop_result, rail_level_result, power_result, current_result;
	logic [7:0] reg_index;
	logic [2:0] avg_select;
	int bad_count, n_tests;
	// group sizes of averaging codes 2 to 7
	int depth [6] = '{16, 64, 128, 256, 512, 1024};
	// cal, sense, rail, current, power
	logic [15:0] tv [3][5] = '{'{16'h0002, 16'h0064, 16'h80fa, 16'h00c8, 16'h07d0},
		'{16'h8001, 16'h8300, 16'h0002, 16'h8300, 16'h0a00},
		'{16'h0001, 16'h7fff, 16'h7fff, 16'h7fff, 16'hffff}};
	pmr_result_regs i_dut (.clock, .rst, .conv_sense_valid, .shunt_drop_reading, .conv_rail_valid,
		.rail_level_reading, .calib_value, .avg_select, .reg_rd, .reg_wr, .reg_index, .reg_wdata,
		.reg_rdata, .sense_drop_result, .rail_level_result, .power_result, .current_result,
		.update_pulse);
	pmr_host i_host (.clock, .reg_rdata, .reg_rd, .reg_wr, .reg_index, .reg_wdata);
	// ==========================================
	// checking and closing
	task chk(string name, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task results();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait; a hang counts as a mismatch
	task wait_pulse();
		int i;
		for (i = 0; i < 300 && update_pulse !== 1'b1; i++)
			@(negedge clock);
		if (i == 300) begin
			bad_count++;
			results();
		end
		@(negedge clock);
		chk("pulse width", {15'h0000, update_pulse}, 16'h0000);
	endtask
	task send(logic sel, logic [15:0] v);
		@(negedge clock);
		conv_sense_valid = !sel;
		conv_rail_valid = sel;
		if (sel) rail_level_reading = v; else shunt_drop_reading = v;
		@(negedge clock);
		conv_sense_valid = 1'b0;
		conv_rail_valid = 1'b0;
		if (sel) rail_level_reading = ~v; else shunt_drop_reading = ~v;
	endtask
	// ==========================================
	// scenarios
	task t_reset();
		for (int i = 1; i < 5; i++) begin
			i_host.rd(i[7:0], d);
			chk("reset read", d, 16'h0000);
		end
	endtask
	task t_calc();
		for (int k = 0; k < 3; k++) begin
			calib_value = tv[k][0];
			send(1'b0, tv[k][1]);
			wait_pulse();
			send(1'b1, tv[k][2]);
			wait_pulse();
			chk("sense", sense_drop_result, tv[k][1]);
			chk("rail", rail_level_result, {1'b0, tv[k][2][14:0]});
			chk("current", current_result, tv[k][3]);
			chk("power", power_result, tv[k][4]);
			i_host.rd(8'h03, d);
			chk("power read", d, tv[k][4]);
		end
	endtask
	task t_avg();
		avg_select = 3'h1;
		repeat (4) @(negedge clock);
		for (int j = 0; j < 4; j++) begin
			send(1'b0, 16'h0004 * (j + 1));
			send(1'b1, (j < 2) ? 16'h0064 : 16'h00c8);
			if (j == 2) chk("sense held", sense_drop_result, 16'h7fff);
			repeat (60) @(negedge clock);
		end
		i_host.rd(8'h01, d);
		chk("sense avg", d, 16'h000a);
		i_host.rd(8'h02, d);
		chk("rail avg", d, 16'h0096);
		chk("power avg", power_result, 16'h003c);
	endtask
	task t_write();
		i_host.wr(8'h01, 16'hffff);
		i_host.wr(8'h03, 16'h1234);
		i_host.rd(8'h01, d);
		chk("sense after write", d, 16'h000a);
		i_host.rd(8'h03, d);
		chk("power after write", d, 16'h003c);
		i_host.rd(8'h07, d);
		chk("unmapped", d, 16'h0000);
	endtask
	// deeper averaging codes; +16 and -8 alternate around a mean of 4 plus the code step
	task t_modes();
		for (int m = 0; m < 6; m++) begin
			avg_select = m[2:0] + 3'h2;
			for (int j = 0; j < depth[m]; j++)
				send(1'b0, j[0] ? 16'hfff8 + m[15:0] : 16'h0010 + m[15:0]);
			repeat (2) @(negedge clock);
			chk("sense depth", sense_drop_result, 16'h0004 + m[15:0]);
		end
		repeat (50) @(negedge clock);
		chk("current depth", current_result, 16'h0009);
		chk("power depth", power_result, 16'h0036);
	endtask
	// free-running clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// main sequence
	initial begin
		rst = 1'b1;
		{conv_sense_valid, conv_rail_valid} = 2'b00;
		shunt_drop_reading = 16'h0000;
		rail_level_reading = 16'h0000;
		calib_value = 16'h0000;
		avg_select = 3'h0;
		repeat (6) @(negedge clock);
		rst = 1'b0;
		t_reset();
		t_calc();
		t_avg();
		t_write();
		t_modes();
		results();
	end
endmodule
